// ===== verilog/shunt_amp_pkg.sv
package shunt_amp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] AMP_CTRL_ADDR   = 7'h0d;  // Amplifier control register
  localparam logic [6:0] HS_CURRENT_ADDR = 7'h0e;  // High-side source/sink current
  localparam logic [6:0] LS_CURRENT_ADDR = 7'h0f;  // Low-side source/sink current
  localparam logic [7:0] AMP_CTRL_RESET  = 8'h01;  // Gain 20 V/V, all else off
  localparam logic [7:0] CURRENT_RESET   = 8'h88;  // Mid-scale drive current
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;  // Answer for unknown address
  localparam logic [11:0] PINS_IDLE      = 12'h400; // Pin levels at rest: select high

  // ----------------------------------------------------------------
  // Amplifier control field positions
  // ----------------------------------------------------------------
  localparam int SH_EN_BIT   = 7;  // Sample-and-hold enable
  localparam int BLK_SEL_BIT = 6;  // Blanking trigger source
  localparam int BLK_MSB     = 5;  // Blanking duration, top bit
  localparam int BLK_LSB     = 3;  // Blanking duration, low bit
  localparam int DIV_BIT     = 2;  // Reference divider
  localparam int GAIN_MSB    = 1;  // Gain select, top bit
  localparam int GAIN_LSB    = 0;  // Gain select, low bit

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS  = 5'h10;  // Bits in one frame
  localparam logic [4:0] HEADER_BITS = 5'h08;  // Read flag plus address
  localparam int         READ_BIT    = 15;     // Frame bit flagging a read
  localparam int         ADDR_MSB    = 14;     // Frame address, top bit
  localparam int         ADDR_LSB    = 8;      // Frame address, low bit

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLOCK_PERIOD_NS     = 10;    // 100 MHz system clock
  localparam int          GATE_WINDOW_TIME_NS = 4000;  // Gate drive window
  localparam int          TIMER_WIDTH         = 16;    // Width of window counters
  localparam logic [15:0] GATE_WINDOW_CYCLES  =
    16'(GATE_WINDOW_TIME_NS / CLOCK_PERIOD_NS);        // Longest time, rounded down

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic       sh_en;    // Sample-and-hold enable
    logic       blk_sel;  // 0 half-bridge 1, 1 half-bridge 2
    logic [2:0] blk;      // Blanking duration code
    logic       div;      // 0 reference / 2, 1 reference / 8
    logic [1:0] gain;     // 10, 20, 40, 80 V/V
  } amp_ctrl_s;

  typedef struct packed
  {
    logic [3:0] source;   // Gate source current code
    logic [3:0] sink;     // Gate sink current code
  } gate_current_s;

  typedef enum logic [2:0]
  {
    SPI_IDLE  = 3'b001,   // Chip select released
    SPI_SHIFT = 3'b010,   // Shifting frame bits
    SPI_DONE  = 3'b100    // Frame complete, extra clocks ignored
  } spi_state_e;

  // Blanking length: code n (1..7) gives (n+1)/8 of the window
  function automatic logic [15:0] blank_cycles(input logic [2:0] code,
                                               input logic [15:0] window);
    logic [19:0] product;
    product = 20'(window) * 20'({1'b0, code} + 4'h1);
    if (code == 3'h0)
      blank_cycles = 16'h0000;
    else
      blank_cycles = product[18:3];
  endfunction

endpackage

// ===== verilog/window_timer.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// One-shot down counter: busy for i_limit cycles after i_start
// ------------------------------------------------------------------
module window_timer #(
  parameter int WIDTH = 16                  // Counter width
) (
  input  wire logic             i_clock,    // System clock
  input  wire logic             i_rst_n,    // Synchronous reset, active low
  input  wire logic             i_start,    // Restart pulse
  input  wire logic [WIDTH-1:0] i_limit,    // Length in cycles, zero means none
  output logic                  o_busy,     // High while counting
  output logic                  o_expire    // One-cycle pulse at the end
);

  logic [WIDTH-1:0] count_reg;               // Cycles still to run
  logic [WIDTH-1:0] count_next;
  logic             expire_reg;              // End-of-window pulse
  logic             expire_next;

  // Restart takes priority so a new edge always gets a full window
  always_comb
  begin
    count_next  = count_reg;
    expire_next = 1'b0;
    if (i_start)
      count_next = i_limit;
    else if (count_reg != '0)
    begin
      count_next  = count_reg - WIDTH'(1);
      expire_next = (count_reg == WIDTH'(1));
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      count_reg  <= '0;
      expire_reg <= 1'b0;
    end
    else
    begin
      count_reg  <= count_next;
      expire_reg <= expire_next;
    end
  end

  assign o_busy   = (count_reg != '0);
  assign o_expire = expire_reg;

endmodule // window_timer

// ===== verilog/shunt_amp_control_register.sv
`timescale 1ns/1ps

// Overview of operation
// - Bit 7 sample-and-hold enable, resets off
// - Bit 6 picks blanking half-bridge, resets 0
// - Bits 5:3 blanking fraction, 000 disables
// - Bit 2 reference divide by 2 or 8
// - Bits 1:0 gain 10/20/40/80, reset 01
// - Gate fault when transistor misses window
// - Serial variant: four currents set independently
// - Strapped variant: one pin sets all currents
// - Register at address 0xD, reset 0x1
module shunt_amp_control_register (
  input  wire logic                         i_clock,          // 100 MHz system clock
  input  wire logic                         i_rst_n,          // Sync reset, active low
  input  wire logic                         i_spi_sclk,       // Serial clock pin
  input  wire logic                         i_spi_cs_n,       // Serial select, active low
  input  wire logic                         i_spi_sdi,        // Serial data in
  output logic                              o_spi_sdo,        // Serial data out
  output logic                              o_spi_sdo_oe,     // High while sdo driven
  input  wire logic                         i_pin_strap_mode, // 1 = pin-strapped variant
  input  wire logic [3:0]                   i_gate_current_select_pin, // Current pin
  input  wire logic                         i_hb1_switch,     // Half-bridge 1 gate command
  input  wire logic                         i_hb2_switch,     // Half-bridge 2 gate command
  input  wire logic                         i_gate_command,   // Monitored gate command
  input  wire logic                         i_gate_settled,   // Transistor reached state
  output shunt_amp_pkg::amp_ctrl_s          o_amp_ctrl,       // Amplifier settings
  output logic                              o_amp_blank,      // Amplifier blanking
  output shunt_amp_pkg::gate_current_s      o_hs_current,     // High-side currents
  output shunt_amp_pkg::gate_current_s      o_ls_current,     // Low-side currents
  output logic                              o_gate_fault      // Gate fault flag
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PINS = 12;                 // Width of the synchronised pin bundle

  logic [PINS-1:0] pins_raw;                // Pins as they arrive
  logic [PINS-1:0] sync1_reg;               // First stage, read only by second
  logic [PINS-1:0] sync2_reg;               // Safe copy
  logic [PINS-1:0] sync3_reg;               // Delayed copy for edge detect
  logic [PINS-1:0] sync1_next;
  logic [PINS-1:0] sync2_next;
  logic [PINS-1:0] sync3_next;

  assign pins_raw = {i_spi_sclk, i_spi_cs_n, i_spi_sdi, i_pin_strap_mode,
                     i_gate_current_select_pin, i_hb1_switch, i_hb2_switch,
                     i_gate_command, i_gate_settled};

  // Every pin is asynchronous to i_clock, so all pass two flops
  always_comb
  begin
    sync1_next = pins_raw;
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= shunt_amp_pkg::PINS_IDLE;  // Resting levels, so no false frame
      sync2_reg <= shunt_amp_pkg::PINS_IDLE;  // or edge is seen after reset
      sync3_reg <= shunt_amp_pkg::PINS_IDLE;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
    end
  end

  logic       sclk_rise;                    // Serial clock rising edge
  logic       sclk_fall;                    // Serial clock falling edge
  logic       cs_active;                    // Frame in progress
  logic       sdi_bit;                      // Synchronised data in
  logic       strap_mode;                   // Pin-strapped variant
  logic [3:0] strap_current;                // Strapped current code
  logic       hb1_rise;                     // Half-bridge 1 switch-on edge
  logic       hb2_rise;                     // Half-bridge 2 switch-on edge
  logic       gate_cmd_edge;                // Any change of gate command
  logic       gate_settled;                 // Synchronised settle status

  assign sclk_rise     = sync2_reg[11] & ~sync3_reg[11];
  assign sclk_fall     = ~sync2_reg[11] & sync3_reg[11];
  assign cs_active     = ~sync2_reg[10];
  assign sdi_bit       = sync2_reg[9];
  assign strap_mode    = sync2_reg[8];
  assign strap_current = sync2_reg[7:4];
  assign hb1_rise      = sync2_reg[3] & ~sync3_reg[3];
  assign hb2_rise      = sync2_reg[2] & ~sync3_reg[2];
  assign gate_cmd_edge = sync2_reg[1] ^ sync3_reg[1];
  assign gate_settled  = sync2_reg[0];

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  shunt_amp_pkg::spi_state_e state_reg;     // Frame state
  shunt_amp_pkg::spi_state_e state_next;
  logic [15:0] shift_in_reg;                // Received bits, MSB first
  logic [15:0] shift_in_next;
  logic [4:0]  bit_cnt_reg;                 // Bits received this frame
  logic [4:0]  bit_cnt_next;
  logic [7:0]  shift_out_reg;               // Read data being sent
  logic [7:0]  shift_out_next;
  logic        sdo_reg;                     // Serial data out flop
  logic        sdo_next;
  logic        sdo_oe_reg;                  // Drive enable flop
  logic        sdo_oe_next;
  logic        wr_stb;                      // Write strobe, one cycle
  logic [6:0]  wr_addr;                     // Write address
  logic [7:0]  wr_data;                     // Write data
  logic [15:0] frame;                       // Frame including the newest bit
  logic [7:0]  rd_data;                     // Read mux output

  logic [7:0]  amp_reg;                     // Amplifier control storage
  logic [7:0]  amp_next;
  logic [7:0]  hs_reg;                      // High-side current storage
  logic [7:0]  hs_next;
  logic [7:0]  ls_reg;                      // Low-side current storage
  logic [7:0]  ls_next;

  assign frame = {shift_in_reg[14:0], sdi_bit};

  // read back
  // Plain mux of stored values, so a read changes nothing
  always_comb
  begin
    case (frame[6:0])
      shunt_amp_pkg::AMP_CTRL_ADDR:   rd_data = amp_reg;
      shunt_amp_pkg::HS_CURRENT_ADDR: rd_data = hs_reg;
      shunt_amp_pkg::LS_CURRENT_ADDR: rd_data = ls_reg;
      default:                        rd_data = shunt_amp_pkg::UNMAPPED_READ;
    endcase
  end

  // Bits are taken on sclk rise and sent on sclk fall
  always_comb
  begin
    state_next     = state_reg;
    shift_in_next  = shift_in_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_out_next = shift_out_reg;
    sdo_next       = sdo_reg;
    sdo_oe_next    = cs_active;
    wr_stb         = 1'b0;
    wr_addr        = frame[shunt_amp_pkg::ADDR_MSB:shunt_amp_pkg::ADDR_LSB];
    wr_data        = frame[7:0];
    case (state_reg)
      shunt_amp_pkg::SPI_IDLE:
      begin
        // New frame: clear counters so stray bits never carry over
        sdo_next = 1'b0;
        if (cs_active)
        begin
          state_next     = shunt_amp_pkg::SPI_SHIFT;
          bit_cnt_next   = 5'h00;
          shift_out_next = 8'h00;
        end
      end
      shunt_amp_pkg::SPI_SHIFT:
      begin
        if (!cs_active)
          state_next = shunt_amp_pkg::SPI_IDLE;     // Short frame is dropped
        else if (sclk_rise)
        begin
          shift_in_next = frame;
          bit_cnt_next  = bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == shunt_amp_pkg::HEADER_BITS - 5'h01)
            shift_out_next = rd_data;               // Header complete
          if (bit_cnt_reg == shunt_amp_pkg::FRAME_BITS - 5'h01)
          begin
            state_next = shunt_amp_pkg::SPI_DONE;
            wr_stb     = ~frame[shunt_amp_pkg::READ_BIT];
          end
        end
        else if (sclk_fall)
        begin
          sdo_next       = shift_out_reg[7];
          shift_out_next = {shift_out_reg[6:0], 1'b0};
        end
      end
      shunt_amp_pkg::SPI_DONE:
      begin
        if (!cs_active)
          state_next = shunt_amp_pkg::SPI_IDLE;
      end
      default:
        state_next = shunt_amp_pkg::SPI_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_reg     <= shunt_amp_pkg::SPI_IDLE;
      shift_in_reg  <= 16'h0000;
      bit_cnt_reg   <= 5'h00;
      shift_out_reg <= 8'h00;
      sdo_reg       <= 1'b0;
      sdo_oe_reg    <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      shift_in_reg  <= shift_in_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_out_reg <= shift_out_next;
      sdo_reg       <= sdo_next;
      sdo_oe_reg    <= sdo_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // address decode
  // Full 8-bit write; every field of the control byte is read/write
  always_comb
  begin
    amp_next = amp_reg;
    hs_next  = hs_reg;
    ls_next  = ls_reg;
    if (wr_stb)
    begin
      case (wr_addr)
        shunt_amp_pkg::AMP_CTRL_ADDR:   amp_next = wr_data;
        shunt_amp_pkg::HS_CURRENT_ADDR: hs_next  = wr_data;
        shunt_amp_pkg::LS_CURRENT_ADDR: ls_next  = wr_data;
        default:                        amp_next = amp_reg;  // Unmapped, ignored
      endcase
    end
  end

  // reset values
  // Reset value 0x01 clears every field except gain code 01
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      amp_reg <= shunt_amp_pkg::AMP_CTRL_RESET;
      hs_reg  <= shunt_amp_pkg::CURRENT_RESET;
      ls_reg  <= shunt_amp_pkg::CURRENT_RESET;
    end
    else
    begin
      amp_reg <= amp_next;
      hs_reg  <= hs_next;
      ls_reg  <= ls_next;
    end
  end

  // ----------------------------------------------------------------
  // Blanking and gate window timing
  // ----------------------------------------------------------------
  logic        blank_start;                 // Selected half-bridge switched on
  logic        blank_busy;                  // Blanking window active
  logic        gate_busy;                   // Gate window active
  logic        gate_expire;                 // Gate window just ended
  logic [15:0] blank_limit;                 // Blanking length in cycles

  assign blank_start = amp_reg[shunt_amp_pkg::BLK_SEL_BIT] ? hb2_rise : hb1_rise;

  assign blank_limit = shunt_amp_pkg::blank_cycles(
                         amp_reg[shunt_amp_pkg::BLK_MSB:shunt_amp_pkg::BLK_LSB],
                         shunt_amp_pkg::GATE_WINDOW_CYCLES);

  window_timer #(
    .WIDTH    (shunt_amp_pkg::TIMER_WIDTH)
  ) u_blank_timer (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_start  (blank_start),
    .i_limit  (blank_limit),
    .o_busy   (blank_busy),
    .o_expire ()
  );

  window_timer #(
    .WIDTH    (shunt_amp_pkg::TIMER_WIDTH)
  ) u_gate_timer (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_start  (gate_cmd_edge),
    .i_limit  (shunt_amp_pkg::GATE_WINDOW_CYCLES),
    .o_busy   (gate_busy),
    .o_expire (gate_expire)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic                         settled_seen_reg;  // Settled during this window
  logic                         settled_seen_next;
  logic                         fault_reg;         // Gate fault flag
  logic                         fault_next;
  logic                         blank_reg;         // Registered blanking
  logic                         blank_next;
  shunt_amp_pkg::gate_current_s hs_cur_reg;        // High-side current out
  shunt_amp_pkg::gate_current_s hs_cur_next;
  shunt_amp_pkg::gate_current_s ls_cur_reg;        // Low-side current out
  shunt_amp_pkg::gate_current_s ls_cur_next;

  always_comb
  begin
    blank_next = blank_busy;
    // gate fault
    // A new command clears the flag, but a miss in the same cycle wins
    settled_seen_next = gate_cmd_edge ? 1'b0 : (settled_seen_reg | (gate_busy & gate_settled));
    fault_next        = gate_cmd_edge ? 1'b0 : fault_reg;
    if (gate_expire && !settled_seen_reg && !gate_settled)
      fault_next = 1'b1;
    // strapped currents
    // One pin value sets both source and sink on both sides
    if (strap_mode)
    begin
      hs_cur_next = {strap_current, strap_current};
      ls_cur_next = {strap_current, strap_current};
    end
    else
    begin
      hs_cur_next = hs_reg;
      ls_cur_next = ls_reg;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      settled_seen_reg <= 1'b0;
      fault_reg        <= 1'b0;
      blank_reg        <= 1'b0;
      hs_cur_reg       <= shunt_amp_pkg::CURRENT_RESET;
      ls_cur_reg       <= shunt_amp_pkg::CURRENT_RESET;
    end
    else
    begin
      settled_seen_reg <= settled_seen_next;
      fault_reg        <= fault_next;
      blank_reg        <= blank_next;
      hs_cur_reg       <= hs_cur_next;
      ls_cur_reg       <= ls_cur_next;
    end
  end

  assign o_spi_sdo    = sdo_reg;
  assign o_spi_sdo_oe = sdo_oe_reg;
  assign o_amp_ctrl   = amp_reg;
  assign o_amp_blank  = blank_reg;
  assign o_hs_current = hs_cur_reg;
  assign o_ls_current = ls_cur_reg;
  assign o_gate_fault = fault_reg;

endmodule // shunt_amp_control_register

// ===== testbench/shunt_amp_properties.sv
`timescale 1ns/1ps

// ----------------------------------------------
// Port checks for the amplifier control block
// ----------------------------------------------
module shunt_amp_properties (
  input wire logic                         i_clock,          // Clock
  input wire logic                         i_rst_n,          // Reset, active low
  input wire logic                         i_spi_cs_n,       // Select
  input wire logic                         o_spi_sdo_oe,     // Data out enable
  input wire logic                         i_pin_strap_mode, // Strapped variant
  input wire logic [3:0]                   i_gate_current_select_pin, // Pin code
  input wire logic                         i_hb1_switch,     // Half-bridge 1
  input wire logic                         i_hb2_switch,     // Half-bridge 2
  input wire logic                         i_gate_command,   // Gate command
  input wire logic                         i_gate_settled,   // Gate settled
  input wire shunt_amp_pkg::amp_ctrl_s     o_amp_ctrl,       // Settings
  input wire logic                         o_amp_blank,      // Blanking
  input wire shunt_amp_pkg::gate_current_s o_hs_current,     // High side
  input wire shunt_amp_pkg::gate_current_s o_ls_current,     // Low side
  input wire logic                         o_gate_fault      // Fault
);
  logic [7:0]  hb1_seen;  // Recent half-bridge 1 levels
  logic [7:0]  hb2_seen;  // Recent half-bridge 2 levels
  logic [7:0]  cmd_moved; // Recent command edges
  logic        cmd_last;  // Command one cycle back
  logic [15:0] low_run;   // Cycles since settled was high

  // Short histories let an effect look back past the input synchronisers
  always_ff @(posedge i_clock)
  begin
    hb1_seen  <= {hb1_seen[6:0], i_hb1_switch};
    hb2_seen  <= {hb2_seen[6:0], i_hb2_switch};
    cmd_last  <= i_gate_command;
    cmd_moved <= {cmd_moved[6:0], i_gate_command ^ cmd_last};
    // Saturates, so a long idle stretch cannot wrap back to zero
    if (!i_rst_n || i_gate_settled)
      low_run <= 16'h0000;
    else if (low_run != 16'hffff)
      low_run <= low_run + 16'h0001;
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_strap_held; (i_pin_strap_mode && $stable(i_gate_current_select_pin)) [*5]; endsequence
  sequence s_serial_quiet; (!i_pin_strap_mode && i_spi_cs_n) [*8]; endsequence

  property p_reset_values; $rose(i_rst_n) |-> o_amp_ctrl == 8'h01 && !o_gate_fault; endproperty
  a_reset_values: assert property (p_reset_values) else $error("Reset value wrong");
  property p_ctrl_quiet; i_spi_cs_n [*8] |=> $stable(o_amp_ctrl); endproperty
  a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("Settings moved idle");
  property p_sdo_drive; $stable(i_spi_cs_n) [*4] |-> o_spi_sdo_oe == !i_spi_cs_n; endproperty
  a_sdo_drive: assert property (p_sdo_drive) else $error("Data out enable wrong");
  property p_strap_current; s_strap_held |-> {o_hs_current, o_ls_current}
    == {4{i_gate_current_select_pin}}; endproperty
  a_strap_current: assert property (p_strap_current) else $error("Strap current wrong");
  property p_serial_current; s_serial_quiet |=> $stable({o_hs_current, o_ls_current}); endproperty
  a_serial_current: assert property (p_serial_current) else $error("Current moved");
  property p_blank_cause; $rose(o_amp_blank) |-> o_amp_ctrl.blk != 3'h0 &&
    (o_amp_ctrl.blk_sel ? hb2_seen != 8'h00 : hb1_seen != 8'h00); endproperty
  a_blank_cause: assert property (p_blank_cause) else $error("Blanking uncaused");
  property p_fault_cause; $rose(o_gate_fault) |-> low_run >= 16'h0186; endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("Fault too early");
  property p_fault_hold; $fell(o_gate_fault) |-> cmd_moved != 8'h00; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("Fault cleared alone");
endmodule // shunt_amp_properties

bind shunt_amp_control_register shunt_amp_properties i_props (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n), .o_spi_sdo_oe(o_spi_sdo_oe),
  .i_pin_strap_mode(i_pin_strap_mode), .i_gate_current_select_pin(i_gate_current_select_pin),
  .i_hb1_switch(i_hb1_switch), .i_hb2_switch(i_hb2_switch), .i_gate_command(i_gate_command),
  .i_gate_settled(i_gate_settled), .o_amp_ctrl(o_amp_ctrl), .o_amp_blank(o_amp_blank),
  .o_hs_current(o_hs_current), .o_ls_current(o_ls_current), .o_gate_fault(o_gate_fault));

// ===== testbench/spi_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------
// Serial host: MSB first, data set while sclk low
// ----------------------------------------------
module spi_host_model (
  input  wire logic i_clock, // Paces the serial clock
  input  wire logic i_sdo,   // Data from the device
  output logic      o_sclk,  // Still between frames
  output logic      o_cs_n,  // Select, active low
  output logic      o_sdi    // Data to the device
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // Five-cycle half period stays above the 40 ns minimum
  task automatic frame(input logic [15:0] tx, input int bits, output logic [7:0] rx);
    rx = 8'h00;
    repeat (5) @(negedge i_clock);
    o_cs_n = 1'b0;
    for (int b = 15; b > 15 - bits; b--)
    begin
      o_sdi = tx[b];
      repeat (5) @(negedge i_clock);
      o_sclk = 1'b1;
      if (b < 8)
        rx[b] = i_sdo;
      repeat (5) @(negedge i_clock);
      o_sclk = 1'b0;
    end
    // Released line shows the inverse, never a stale bit
    o_sdi = ~o_sdi;
    repeat (5) @(negedge i_clock);
    o_cs_n = 1'b1;
  endtask
endmodule // spi_host_model

// ===== testbench/tb.sv
`timescale 1ns/1ps

`define CHECK(got, exp) \
  begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

// ----------------------------------------------
// Amplifier control bench
// ----------------------------------------------
module tb;
  logic clock, sclk, cs_n, sdi, sdo, sdo_oe, blank, fault;           // Clock and outputs
  logic rst_n = 1'b0, strap = 1'b0, hb1 = 1'b0, hb2 = 1'b0;          // Reset, controls
  logic cmd = 1'b0, settled = 1'b0;                                  // Gate monitor inputs
  logic [3:0] pin = 4'h9;                                            // Current pin
  logic [7:0] rx;                                                    // Read data
  logic [7:0] vals [9] = '{8'h80, 8'h40, 8'h08, 8'h38, 8'h04, 8'h02, 8'h03, 8'h00, 8'ha5};
  shunt_amp_pkg::amp_ctrl_s     ctrl;                                // Settings out
  shunt_amp_pkg::gate_current_s hs, ls;                              // Currents out
  int failures = 0, total_checks = 0, cycles = 0, len;               // Counters
  int win = int'(shunt_amp_pkg::GATE_WINDOW_CYCLES);                 // Gate window cycles

  shunt_amp_control_register i_dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .i_pin_strap_mode(strap),
    .i_gate_current_select_pin(pin), .i_hb1_switch(hb1), .i_hb2_switch(hb2),
    .i_gate_command(cmd), .i_gate_settled(settled), .o_amp_ctrl(ctrl), .o_amp_blank(blank),
    .o_hs_current(hs), .o_ls_current(ls), .o_gate_fault(fault));
  spi_host_model i_host (.i_clock(clock), .i_sdo(sdo), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Ceiling well above the roughly 25000 cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.frame({1'b0, a, d}, 16, rx);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    i_host.frame({1'b1, a, 8'h00}, 16, d);
  endtask

  // Edge on one half-bridge, then count cycles of blanking
  task automatic pulse(input int src, output int seen);
    seen = 0;
    hb1 = (src == 0);
    hb2 = (src == 1);
    for (int i = 0; i < win + 100; i++)
    begin
      @(negedge clock);
      hb1 = hb1 && (i < 4);
      hb2 = hb2 && (i < 4);
      if (blank === 1'b1)
        seen++;
    end
  endtask

  initial
  begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHECK({ctrl, hs}, 16'h0188)
    // Single fields first, then a mix; two reads expose read side effects
    foreach (vals[i])
    begin
      wr(7'h0d, vals[i]);
      `CHECK(ctrl, vals[i])
      repeat (2)
      begin
        rd(7'h0d, rx);
        `CHECK(rx, vals[i])
      end
    end
    // Cut frame and unmapped address must leave the settings alone
    i_host.frame({1'b0, 7'h0d, 8'h5a}, 12, rx);
    wr(7'h10, 8'h5a);
    `CHECK(ctrl, 8'ha5)
    rd(7'h10, rx);
    `CHECK(rx, shunt_amp_pkg::UNMAPPED_READ)
    wr(shunt_amp_pkg::HS_CURRENT_ADDR, 8'h3c);
    wr(shunt_amp_pkg::LS_CURRENT_ADDR, 8'hc5);
    `CHECK({hs, ls}, 16'h3cc5)
    strap = 1'b1;
    pin = 4'h6;
    repeat (8) @(negedge clock);
    `CHECK({hs, ls}, 16'h6666)
    strap = 1'b0;
    repeat (8) @(negedge clock);
    `CHECK({hs, ls}, 16'h3cc5)
    // Every blanking code from each source; the other source must stay silent
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 8; c++)
      begin
        wr(7'h0d, {1'b0, s[0], c[2:0], 3'b001});
        pulse(s, len);
        `CHECK(len, (c == 0) ? 0 : win * (c + 1) / 8)
        pulse(1 - s, len);
        `CHECK(len, 0)
      end
    cmd = 1'b1;
    repeat (win + 20) @(negedge clock);
    `CHECK(fault, 1'b1)
    cmd = 1'b0;
    repeat (10) @(negedge clock);
    settled = 1'b1;
    `CHECK(fault, 1'b0)
    repeat (win + 20) @(negedge clock);
    `CHECK(fault, 1'b0)
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHECK({ctrl, hs}, 16'h0188)
    wrap_up();
  end
endmodule // tb
